// file: cce_pkg.sv
/*
 * Shared constants and types for the instruction execution block, plus the
 * watchdog counter that the execution block clears.
 * Assumes one clock (aclk) and a synchronous active-low reset (aresetn).
 */
`default_nettype none

package cce_pkg;
    // register byte offsets on the AXI4-Lite port
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_WREG = 12'h004;
    localparam logic [11:0] OFF_LATCH = 12'h008;
    localparam logic [11:0] OFF_PC = 12'h00C;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_STACK = 12'h014;
    localparam logic [11:0] OFF_WDT = 12'h018;
    // file register window: 0x200..0x3FC, one byte per word
    localparam logic [2:0] FILE_SEL = 3'h1;
    localparam int FILE_DEPTH = 128;
    localparam int STACK_DEPTH = 16;
    // status bit positions
    localparam int ST_ZERO = 0;
    localparam int ST_PD_N = 1;
    localparam int ST_TO_N = 2;
    localparam int ST_BUSY = 3;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [14:0] RST_PC = 15'h0000;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic [7:0] WDT_LAST = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_CALL_VIA_WORKING,
        OP_CLEAR_FILE_REG,
        OP_CLEAR_WORKING,
        OP_KICK_WATCHDOG,
        OP_COMPLEMENT_FILE_REG,
        OP_DECREMENT_FILE_REG,
        OP_DECREMENT_SKIP_ZERO
    } cce_op_e;

    // command word: bits [2:0] op, bit 3 destination, bits [10:4] file address
    typedef struct packed {
        logic [6:0] faddr;
        logic dest;
        cce_op_e op;
    } cce_cmd_s;

    typedef enum logic {
        EX_IDLE,
        EX_SECOND
    } cce_exec_e;
endpackage : cce_pkg

/* watchdog counter with prescaler; kick clears both, wrap gives a pulse */
module cce_watchdog (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic kick,
    output logic [7:0] count,
    output logic timeout
);
    logic [7:0] presc_ff;
    logic [7:0] count_ff;
    logic timeout_ff;

    // prescaler advances the counter once per wrap
    always_ff @(posedge aclk) begin
        if (!aresetn || kick) begin
            presc_ff <= cce_pkg::WDT_CLEAR;
            count_ff <= cce_pkg::WDT_CLEAR;
        end else begin
            presc_ff <= presc_ff + 8'h01;
            if (presc_ff == cce_pkg::WDT_LAST) begin
                count_ff <= count_ff + 8'h01;
            end
        end
    end

    // one-cycle expiry pulse when the counter rolls over
    always_ff @(posedge aclk) begin
        if (!aresetn || kick) begin
            timeout_ff <= 1'b0;
        end else begin
            timeout_ff <= (presc_ff == cce_pkg::WDT_LAST) && (count_ff == cce_pkg::WDT_LAST);
        end
    end

    assign count = count_ff;
    assign timeout = timeout_ff;
endmodule : cce_watchdog

`default_nettype wire

// file: cce_exec.sv
/*
 * Execution unit for computed call, clear, complement, decrement,
 * decrement-and-skip and watchdog clear, with an AXI4-Lite register port.
 * Assumes an AXI4-Lite master that follows the usual valid/ready rules.
 */
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`default_nettype none

module cce_exec (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, aw_held_ff, w_held_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wdata_ff;
    logic [11:0] awaddr_ff;
    logic [3:0] wstrb_ff, sp_ff;
    logic [7:0] wreg_ff;
    logic [6:0] pc_upper_latch_ff;
    logic [14:0] pc_ff;
    logic [10:0] cmd_ff;
    logic zero_ff, timeout_flag_n_ff, powerdown_flag_n_ff;
    cce_pkg::cce_exec_e state_ff;
    logic [14:0] stack_ff [cce_pkg::STACK_DEPTH];
    logic [7:0] file_ff [cce_pkg::FILE_DEPTH];
    logic wr_fire, wr_file, wr_map, exec, to_w, to_f, z_upd, is_rmw, res_zero, kick;
    logic [6:0] wr_idx;
    cce_pkg::cce_cmd_s cmd;
    logic [7:0] fval, res, nxt_fdata, wdt_count;
    logic [14:0] pc_inc;
    logic [31:0] nxt_rdata;
    logic rd_map, wdt_timeout;
    // write is applied once both address and data are held and no answer is pending
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_file = awaddr_ff[11:9] == cce_pkg::FILE_SEL;
    assign wr_idx = awaddr_ff[8:2];
    assign wr_map = wr_file || awaddr_ff <= cce_pkg::OFF_WDT && awaddr_ff[1:0] == 2'h0;
    // decode of the command written to the command register
    assign cmd = cce_pkg::cce_cmd_s'(wdata_ff[10:0]);
    assign exec = wr_fire && awaddr_ff == cce_pkg::OFF_CMD && state_ff == cce_pkg::EX_IDLE;
    assign kick = exec && cmd.op == cce_pkg::OP_KICK_WATCHDOG;
    assign is_rmw = cmd.op == cce_pkg::OP_COMPLEMENT_FILE_REG
        || cmd.op == cce_pkg::OP_DECREMENT_FILE_REG
        || cmd.op == cce_pkg::OP_DECREMENT_SKIP_ZERO;
    assign fval = file_ff[cmd.faddr];
    assign res = cmd.op == cce_pkg::OP_COMPLEMENT_FILE_REG
        ? ~fval : fval - 8'h01;
    assign res_zero = res == 8'h00;
    assign to_w = exec
        && (is_rmw && !cmd.dest || cmd.op == cce_pkg::OP_CLEAR_WORKING);
    assign to_f = exec
        && (is_rmw && cmd.dest || cmd.op == cce_pkg::OP_CLEAR_FILE_REG);
    assign nxt_fdata = cmd.op == cce_pkg::OP_CLEAR_FILE_REG ? 8'h00 : res;
    // skip variant leaves status alone, so only these two follow the result
    assign z_upd = exec && (cmd.op == cce_pkg::OP_COMPLEMENT_FILE_REG
        || cmd.op == cce_pkg::OP_DECREMENT_FILE_REG);
    assign pc_inc = pc_ff + 15'h0001;
    // write address channel: one held address, ready dropped until the answer is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            awaddr_ff <= 12'h000;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
        end
    end
    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
        end
    end
    // write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= cce_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? cce_pkg::RESP_OKAY : cce_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    // last command word, kept for read-back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_ff <= 11'h000;
        end else if (exec) begin
            cmd_ff <= wdata_ff[10:0];
        end
    end
    // second cycle of call and of a taking skip; busy shows in status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= cce_pkg::EX_IDLE;
        end else if (exec && (cmd.op == cce_pkg::OP_CALL_VIA_WORKING
                || cmd.op == cce_pkg::OP_DECREMENT_SKIP_ZERO && res_zero)) begin
            state_ff <= cce_pkg::EX_SECOND;
        end else begin
            state_ff <= cce_pkg::EX_IDLE; // others finish in one cycle
        end
    end
    // working register: instruction result has priority over a bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_ff <= cce_pkg::RST_BYTE;
        end else if (to_w) begin
            wreg_ff <= cmd.op == cce_pkg::OP_CLEAR_WORKING ? 8'h00 : res;
        end else if (wr_fire && awaddr_ff == cce_pkg::OFF_WREG && wstrb_ff[0]) begin
            wreg_ff <= wdata_ff[7:0];
        end
    end
    // upper program counter latch, software owned
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_upper_latch_ff <= 7'h00;
        end else if (wr_fire && awaddr_ff == cce_pkg::OFF_LATCH && wstrb_ff[0]) begin
            pc_upper_latch_ff <= wdata_ff[6:0];
        end
    end
    // program counter: call jumps, a taking skip steps over the discarded word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_ff <= cce_pkg::RST_PC;
        end else if (exec && cmd.op == cce_pkg::OP_CALL_VIA_WORKING) begin
            pc_ff <= {pc_upper_latch_ff, wreg_ff};
        end else if (exec && cmd.op == cce_pkg::OP_DECREMENT_SKIP_ZERO && res_zero) begin
            pc_ff <= pc_ff + 15'h0002;
        end else if (exec) begin
            pc_ff <= pc_inc;
        end else if (wr_fire && awaddr_ff == cce_pkg::OFF_PC) begin
            pc_ff[7:0] <= wstrb_ff[0] ? wdata_ff[7:0] : pc_ff[7:0];
            pc_ff[14:8] <= wstrb_ff[1] ? wdata_ff[14:8] : pc_ff[14:8];
        end
    end
    // return stack pointer; wraps silently on overflow, like a circular stack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_ff <= 4'h0;
        end else if (exec && cmd.op == cce_pkg::OP_CALL_VIA_WORKING) begin
            sp_ff <= sp_ff + 4'h1;
        end
    end
    // stack entries and file registers, one process per entry
    for (genvar i = 0; i < cce_pkg::STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stack_ff[i] <= cce_pkg::RST_PC;
            end else if (exec && cmd.op == cce_pkg::OP_CALL_VIA_WORKING
                    && sp_ff == 4'(i)) begin
                stack_ff[i] <= pc_inc; // return address
            end
        end
    end
    for (genvar i = 0; i < cce_pkg::FILE_DEPTH; i++) begin : g_file
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                file_ff[i] <= cce_pkg::RST_BYTE;
            end else if (to_f && cmd.faddr == 7'(i)) begin
                file_ff[i] <= nxt_fdata;
            end else if (wr_fire && wr_file && wr_idx == 7'(i) && wstrb_ff[0]) begin
                file_ff[i] <= wdata_ff[7:0];
            end
        end
    end
    // zero flag; instruction effect wins over a bus write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_ff <= 1'b0;
        end else if (exec && (cmd.op == cce_pkg::OP_CLEAR_FILE_REG
                || cmd.op == cce_pkg::OP_CLEAR_WORKING)) begin
            zero_ff <= 1'b1;
        end else if (z_upd) begin
            zero_ff <= res_zero;
        end else if (wr_fire && awaddr_ff == cce_pkg::OFF_STATUS && wstrb_ff[0]) begin
            zero_ff <= wdata_ff[cce_pkg::ST_ZERO];
        end
    end
    // active-low timeout and powerdown flags; kick wins over an expiry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_flag_n_ff <= 1'b1;
            powerdown_flag_n_ff <= 1'b1;
        end else if (kick) begin
            timeout_flag_n_ff <= 1'b1;
            powerdown_flag_n_ff <= 1'b1;
        end else if (wdt_timeout) begin
            timeout_flag_n_ff <= 1'b0;
        end
    end
    // watchdog counter and prescaler, cleared by the kick
    cce_watchdog u_watchdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .kick(kick),
        .count(wdt_count),
        .timeout(wdt_timeout)
    );
    // read decode
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        rd_map = 1'b1;
        if (s_axi_araddr[11:9] == cce_pkg::FILE_SEL) begin
            nxt_rdata[7:0] = file_ff[s_axi_araddr[8:2]];
        end else begin
            unique case (s_axi_araddr)
                cce_pkg::OFF_CMD: nxt_rdata[10:0] = cmd_ff;
                cce_pkg::OFF_WREG: nxt_rdata[7:0] = wreg_ff;
                cce_pkg::OFF_LATCH: nxt_rdata[6:0] = pc_upper_latch_ff;
                cce_pkg::OFF_PC: nxt_rdata[14:0] = pc_ff;
                cce_pkg::OFF_STATUS: begin
                    nxt_rdata[cce_pkg::ST_ZERO] = zero_ff;
                    nxt_rdata[cce_pkg::ST_PD_N] = powerdown_flag_n_ff;
                    nxt_rdata[cce_pkg::ST_TO_N] = timeout_flag_n_ff;
                    nxt_rdata[cce_pkg::ST_BUSY] = state_ff == cce_pkg::EX_SECOND;
                end
                cce_pkg::OFF_STACK: nxt_rdata[19:0] = {1'b0, sp_ff, stack_ff[sp_ff - 4'h1]};
                cce_pkg::OFF_WDT: nxt_rdata[7:0] = wdt_count;
                default: rd_map = 1'b0;
            endcase
        end
    end
    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= cce_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= rd_map ? cce_pkg::RESP_OKAY : cce_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule : cce_exec

`default_nettype wire

// file: cce_exec_assertions.sv
/*
 * Checker for the execution block: timing and response relations on the
 * AXI4-Lite port. Assumes the one clock aclk and a synchronous aresetn.
 */
`default_nettype none

module cce_exec_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // answer is given without waiting for a two-cycle call or skip, so it has a fixed place
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late or early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready while data pending");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
    // the gap between the last register word and the file window is unmapped
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > 12'h018 && s_axi_araddr < 12'h200
        |=> s_axi_rresp == cce_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : cce_exec_assertions

bind cce_exec cce_exec_assertions i_cce_exec_assertions (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

`default_nettype wire

// file: test_call_clear_decrement_exec.sv
/*
 * Self-checking bench for the execution block over its AXI4-Lite port.
 * Assumes cce_pkg, cce_exec and the checker are compiled before it.
 */
`default_nettype none

module test_call_clear_decrement_exec;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int num_errors = 0;
    int checks = 0;

    always #2 aclk = ~aclk;

    cce_exec i_cce_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // address and data offered together, each released at its own take
    // local flags: the valids themselves only change after the edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_open;
        logic w_open;
        aw_open = 1'h1;
        w_open = 1'h1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (aw_open || w_open) begin
            @(posedge aclk);
            if (aw_open && awready) begin
                awvalid <= 1'h0;
                aw_open = 1'h0;
            end
            if (w_open && wready) begin
                wvalid <= 1'h0;
                w_open = 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask : wr

    task automatic rdw(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask : rdw

    function automatic logic [31:0] cmd(cce_pkg::cce_op_e op, logic d, logic [6:0] f);
        return {21'h0, f, d, op};
    endfunction : cmd

    function automatic logic [11:0] fa(logic [6:0] f);
        return {cce_pkg::FILE_SEL, f, 2'h0};
    endfunction : fa

    // runs one instruction and checks W, one file register and status
    task automatic exec(input logic [31:0] c, input logic [6:0] f, input logic [7:0] w,
                        input logic [7:0] fv, input logic [31:0] st);
        wr(cce_pkg::OFF_CMD, c);
        rdw(cce_pkg::OFF_WREG);
        chk("working", rd, {24'h0, w});
        rdw(fa(f));
        chk("file", rd, {24'h0, fv});
        rdw(cce_pkg::OFF_STATUS);
        chk("status", rd, st);
    endtask : exec

    task automatic t_clear;
        rdw(cce_pkg::OFF_STATUS);
        chk("reset status", rd, 32'h6);
        wr(fa(7'h7F), 32'h5A);
        wr(cce_pkg::OFF_WREG, 32'h33);
        wr(cce_pkg::OFF_PC, 32'h0100);
        exec(cmd(cce_pkg::OP_CLEAR_FILE_REG, 1'h1, 7'h7F),
            7'h7F, 8'h33, 8'h00, 32'h7);
        rdw(cce_pkg::OFF_PC);
        chk("pc step", rd, 32'h0101);
        wr(cce_pkg::OFF_STATUS, 32'h0);
        exec(cmd(cce_pkg::OP_CLEAR_WORKING, 1'h0, 7'h7F), 7'h7F, 8'h00, 8'h00, 32'h7);
        $display("clear tests done");
    endtask : t_clear

    task automatic t_arith;
        wr(fa(7'h05), 32'h0F);
        wr(cce_pkg::OFF_WREG, 32'h11);
        exec(cmd(cce_pkg::OP_COMPLEMENT_FILE_REG, 1'h1, 7'h05),
            7'h05, 8'h11, 8'hF0, 32'h6);
        exec(cmd(cce_pkg::OP_COMPLEMENT_FILE_REG, 1'h0, 7'h05),
            7'h05, 8'h0F, 8'hF0, 32'h6);
        wr(fa(7'h05), 32'hFF);
        exec(cmd(cce_pkg::OP_COMPLEMENT_FILE_REG, 1'h0, 7'h05),
            7'h05, 8'h00, 8'hFF, 32'h7);
        wr(fa(7'h06), 32'h01);
        exec(cmd(cce_pkg::OP_DECREMENT_FILE_REG, 1'h0, 7'h06),
            7'h06, 8'h00, 8'h01, 32'h7);
        wr(fa(7'h06), 32'h00);
        exec(cmd(cce_pkg::OP_DECREMENT_FILE_REG, 1'h1, 7'h06),
            7'h06, 8'h00, 8'hFF, 32'h6);
        $display("complement and decrement tests done");
    endtask : t_arith

    // zero flag is preset opposite to the result to show it is left alone
    task automatic t_skip;
        wr(cce_pkg::OFF_PC, 32'h0010);
        wr(fa(7'h07), 32'h02);
        wr(cce_pkg::OFF_STATUS, 32'h1);
        exec(cmd(cce_pkg::OP_DECREMENT_SKIP_ZERO, 1'h1, 7'h07),
            7'h07, 8'h00, 8'h01, 32'h7);
        rdw(cce_pkg::OFF_PC);
        chk("pc no skip", rd, 32'h0011);
        wr(cce_pkg::OFF_STATUS, 32'h0);
        wr(cce_pkg::OFF_WREG, 32'h44);
        exec(cmd(cce_pkg::OP_DECREMENT_SKIP_ZERO, 1'h0, 7'h07),
            7'h07, 8'h00, 8'h01, 32'h6);
        rdw(cce_pkg::OFF_PC);
        chk("pc skip", rd, 32'h0013);
        $display("decrement skip tests done");
    endtask : t_skip

    task automatic t_call;
        wr(cce_pkg::OFF_LATCH, 32'h55);
        wr(cce_pkg::OFF_PC, 32'h1234);
        wr(cce_pkg::OFF_STATUS, 32'h1);
        wr(cce_pkg::OFF_WREG, 32'h9A);
        exec(cmd(cce_pkg::OP_CALL_VIA_WORKING, 1'h0, 7'h00), 7'h00, 8'h9A, 8'h00, 32'h7);
        rdw(cce_pkg::OFF_PC);
        chk("call pc", rd, 32'h559A);
        rdw(cce_pkg::OFF_STACK);
        chk("return addr", rd & 32'h7FFF, 32'h1235);
        chk("stack pointer", rd >> 15, 32'h1);
        $display("call test done");
    endtask : t_call

    // expiry first, so the kick has a cleared timeout flag to set again
    task automatic t_kick;
        repeat (65600) @(posedge aclk);
        rdw(cce_pkg::OFF_STATUS);
        chk("expired", rd & 32'h4, 32'h0);
        wr(cce_pkg::OFF_CMD, cmd(cce_pkg::OP_KICK_WATCHDOG, 1'h0, 7'h00));
        rdw(cce_pkg::OFF_STATUS);
        chk("flags set", rd & 32'h6, 32'h6);
        repeat (200) @(posedge aclk);
        rdw(cce_pkg::OFF_WDT);
        chk("wdt cleared", rd, 32'h0);
        wr(12'h100, 32'h1);
        chk("bad write", {30'h0, resp}, {30'h0, cce_pkg::RESP_SLVERR});
        rdw(12'h100);
        chk("bad read", {30'h0, resp}, {30'h0, cce_pkg::RESP_SLVERR});
        chk("bad read data", rd, 32'h0);
        $display("watchdog and unmapped tests done");
    endtask : t_kick

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_clear();
        t_arith();
        t_skip();
        t_call();
        t_kick();
        conclude();
    end

    // about 66000 cycles expected; cut off well past that
    initial begin
        #400000;
        num_errors++;
        conclude();
    end
endmodule : test_call_clear_decrement_exec

`default_nettype wire
